/* common/event_vec_pkg.sv */
// constants for the event priority and vectoring unit
package event_vec_pkg;
   localparam int ADDR_W = 32; // address width
   localparam int NUM_EV = 28; // number of event priorities
   localparam int STAGES = 3; // pipeline stages watched
   localparam int AUTOVEC_W = 14; // autovector offset width
   localparam logic [31:0] RESET_ADDR = 32'h8000_0000; // reset entry
   localparam logic [31:0] SCALL_RET_INC = 32'h0000_0002; // scall step
   // priority numbers of special events
   localparam int PRI_RESET = 1;
   localparam int PRI_DEBUG = 2;
   localparam int PRI_BUS_DATA = 5;
   localparam int PRI_BUS_INSTR = 6;
   localparam int PRI_NMI = 7;
   localparam int PRI_INT3 = 8;
   localparam int PRI_INT0 = 11;
   localparam int PRI_FPU = 19;
   localparam int PRI_SCALL = 21;
   localparam int PRI_MODIFIED = 28;
   // handler offsets, index = priority - 1
   localparam logic [31:0] EV_OFFSET [NUM_EV] = '{
      32'h0, 32'h0, 32'h00, 32'h04, 32'h08, 32'h0c, 32'h10,
      32'h0, 32'h0, 32'h0, 32'h0,
      32'h14, 32'h50, 32'h18, 32'h1c, 32'h20, 32'h24, 32'h28,
      32'h2c, 32'h30, 32'h100, 32'h34, 32'h38, 32'h60, 32'h70,
      32'h3c, 32'h40, 32'h44};
   // return address kinds
   typedef enum logic [1:0] {
      RET_NONE = 2'b00, // undefined
      RET_FNC = 2'b01, // first non-completed instruction
      RET_PC = 2'b10, // offending instruction
      RET_SCALL = 2'b11 // supervisor call plus two
   } ret_kind_e;
   // mask bits that are never set: 1,3,4,5,6,7 (reset,unrec,mhit,bus,nmi)
   localparam logic [NUM_EV-1:0] UNMASKABLE = 28'h000_007d;
   // floating point and page-modified slots are never raised
   localparam logic [NUM_EV-1:0] RESERVED_EV = 28'h804_0000;
endpackage

/* src/event_pick.sv */
// priority picker: lowest set index of a vector
`timescale 1ns/1ns
`default_nettype none
module event_pick #(
   parameter int N = 28 // request width
) (
   input wire logic [N-1:0] req, // request bits, bit 0 highest
   output logic any, // some request set
   output logic [$clog2(N)-1:0] idx // index of the winner
);
   // scan from the high end so the lowest number is written last and wins
   always_comb begin
      any = 1'b0;
      idx = '0;
      for (int i = N - 1; i >= 0; i--) begin
         if (req[i]) begin
            any = 1'b1;
            idx = i[$clog2(N)-1:0];
         end
      end
   end
endmodule
`default_nettype wire

/* src/event_priority_vectoring.sv */
// event arbitration, handler address and return address selection
//
// Summary of operation
// - oldest pipeline instruction's events served first
// - lowest priority number wins; reset at fixed address
// - debug stop: debug-supplied target, first non-completed
// - data bus error: base|0x08, first non-completed
// - instruction bus error: base|0x0c, first non-completed
// - floating-point and page-modified events never raised
// - interrupt autovector offset is 14 bits
// - target is base OR offset, not sum
// - accept sets equal/lower masks, critical unmaskable
`timescale 1ns/1ns
`default_nettype none
module event_priority_vectoring
   import event_vec_pkg::*;
#(
   parameter int STAGE_N = event_vec_pkg::STAGES // stages watched
) (
   input wire logic clk, // cpu clock
   input wire logic sys_rst, // synchronous reset, active high
   input wire logic [STAGE_N*event_vec_pkg::NUM_EV-1:0] stage_events,
      // per stage event bits, stage 0 oldest, bit 0 = priority 1
   input wire logic [STAGE_N*32-1:0] stage_pc, // pc per stage
   input wire logic [31:0] first_noncompleted_pc, // resume point
   input wire logic [31:0] event_vector_base, // vector base register
   input wire logic [event_vec_pkg::AUTOVEC_W-1:0] autovector, // from intc
   input wire logic [31:0] debug_target, // debug unit handler address
   input wire logic [event_vec_pkg::NUM_EV-1:0] mask_in, // current masks
   output logic take, // event accepted: high the cycle after any cycle with a qualified request and sys_rst low
   output logic [31:0] handler_addr, // new program counter
   output logic [31:0] return_addr, // address to save
   output logic [4:0] accepted_pri, // priority number taken
   output logic [$clog2(STAGE_N+1)-1:0] accepted_stage, // stage taken
   output logic [event_vec_pkg::NUM_EV-1:0] mask_out // masks after take
);
   import event_vec_pkg::*;

   localparam int IW = $clog2(NUM_EV); // priority index width
   localparam int SW = $clog2(STAGE_N + 1); // stage index width

   // return kind per priority index
   function automatic ret_kind_e ret_kind(input logic [IW-1:0] i);
      int p;
      p = int'(i) + 1;
      if (p == PRI_RESET) return RET_NONE;
      if (p >= PRI_DEBUG && p <= 2) return RET_FNC;
      if (p == 3 || p == 4) return RET_PC;
      if (p >= PRI_BUS_DATA && p <= PRI_INT0) return RET_FNC;
      if (p == 15) return RET_FNC; // breakpoint
      if (p == PRI_SCALL) return RET_SCALL;
      return RET_PC;
   endfunction

   // handler target per priority index
   function automatic logic [31:0] target(input logic [IW-1:0] i,
      input logic [31:0] base, input logic [AUTOVEC_W-1:0] av,
      input logic [31:0] dbg);
      int p;
      p = int'(i) + 1;
      if (p == PRI_RESET) return RESET_ADDR;
      if (p == PRI_DEBUG) return dbg;
      if (p >= PRI_INT3 && p <= PRI_INT0)
         return base | {{(32-AUTOVEC_W){1'b0}}, av};
      return base | EV_OFFSET[i];
   endfunction

   // per stage candidate requests, after masking and reserved slots
   logic [NUM_EV-1:0] stage_req [STAGE_N]; // qualified requests
   logic [STAGE_N-1:0] stage_any; // stage has something pending
   logic [IW-1:0] stage_idx [STAGE_N]; // winner per stage

   genvar g;
   generate
      for (g = 0; g < STAGE_N; g++) begin : g_stage
         // masked events drop out; critical ones pass regardless
         assign stage_req[g] = stage_events[g*NUM_EV +: NUM_EV]
            & ~(mask_in & ~UNMASKABLE) & ~RESERVED_EV;
         event_pick #(.N(NUM_EV)) u_pick (
            .req(stage_req[g]),
            .any(stage_any[g]),
            .idx(stage_idx[g])
         );
      end
   endgenerate

   // next-value group
   logic next_take; // accept this cycle
   logic [31:0] next_handler; // chosen target
   logic [31:0] next_ret; // chosen return address
   logic [4:0] next_pri; // chosen priority number
   logic [SW-1:0] next_stage; // chosen stage
   logic [NUM_EV-1:0] next_mask; // masks after acceptance
   logic [IW-1:0] win; // winning index
   logic [31:0] win_pc; // pc of winning stage

   // choose oldest stage, then its highest priority event
   always_comb begin
      next_take = 1'b0;
      next_handler = handler_addr;
      next_ret = return_addr;
      next_pri = accepted_pri;
      next_stage = accepted_stage;
      next_mask = mask_in;
      win = '0;
      win_pc = '0;
      // high stage first so stage 0 (oldest) is the last to win
      for (int s = STAGE_N - 1; s >= 0; s--) begin
         if (stage_any[s]) begin
            next_take = 1'b1;
            win = stage_idx[s];
            win_pc = stage_pc[s*32 +: 32];
            next_stage = s[SW-1:0];
         end
      end
      if (next_take) begin
         next_pri = 5'(int'(win) + 1);
         next_handler = target(win, event_vector_base, autovector,
            debug_target);
         unique case (ret_kind(win))
            RET_NONE: next_ret = '0; // reset: no meaningful return
            RET_FNC: next_ret = first_noncompleted_pc;
            RET_PC: next_ret = win_pc;
            RET_SCALL: next_ret = win_pc + SCALL_RET_INC;
         endcase
         // set masks of equal and lower priority, critical keep their mask_in value
         for (int k = 0; k < NUM_EV; k++) begin
            if (k >= int'(win) && !UNMASKABLE[k])
               next_mask[k] = 1'b1;
         end
      end
   end

   // register the chosen event
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         take <= 1'b0;
         handler_addr <= RESET_ADDR;
         return_addr <= '0;
         accepted_pri <= 5'h00;
         accepted_stage <= '0;
         mask_out <= '0;
      end else begin
         take <= next_take;
         handler_addr <= next_handler;
         return_addr <= next_ret;
         accepted_pri <= next_pri;
         accepted_stage <= next_stage;
         mask_out <= next_mask;
      end
   end

   // checks
   a_reset_vector: assert property (
      @(posedge clk) disable iff (sys_rst)
      stage_req[0][0] |=> take && handler_addr == RESET_ADDR)
      else $error("reset not vectored to reset address");
   a_oldest_first: assert property (
      @(posedge clk) disable iff (sys_rst)
      stage_any[0] |=> take && accepted_stage == '0)
      else $error("younger stage served before oldest");
   a_debug_target: assert property (
      @(posedge clk) disable iff (sys_rst)
      take && accepted_pri == 5'h02 |-> handler_addr == $past(debug_target)
      && return_addr == $past(first_noncompleted_pc))
      else $error("debug stop target or return wrong");
   a_bus_data: assert property (
      @(posedge clk) disable iff (sys_rst)
      take && accepted_pri == 5'h05 |->
      handler_addr == ($past(event_vector_base) | 32'h08)
      && return_addr == $past(first_noncompleted_pc))
      else $error("data bus error target wrong");
   a_bus_instr: assert property (
      @(posedge clk) disable iff (sys_rst)
      take && accepted_pri == 5'h06 |->
      handler_addr == ($past(event_vector_base) | 32'h0c)
      && return_addr == $past(first_noncompleted_pc))
      else $error("instruction bus error target wrong");
   a_no_reserved: assert property (
      @(posedge clk) disable iff (sys_rst)
      take |-> accepted_pri != 5'h13 && accepted_pri != 5'h1c)
      else $error("reserved event raised");
   a_autovec_span: assert property (
      @(posedge clk) disable iff (sys_rst)
      take && accepted_pri >= 5'h08 && accepted_pri <= 5'h0b |->
      (handler_addr & ~$past(event_vector_base) & 32'hffff_c000) == '0)
      else $error("autovector outside span");
   a_or_target: assert property (
      @(posedge clk) disable iff (sys_rst)
      take && accepted_pri == 5'h0c |->
      handler_addr == ($past(event_vector_base) | 32'h14))
      else $error("target not formed by or");
   // lowest slot always gets masked; unmaskable bits pass through untouched
   a_mask_set: assert property (
      @(posedge clk) disable iff (sys_rst)
      take |-> mask_out[NUM_EV-1]
      && (mask_out & UNMASKABLE) == ($past(mask_in) & UNMASKABLE))
      else $error("mask update wrong");
   a_scall_ret: assert property (
      @(posedge clk) disable iff (sys_rst)
      take && accepted_pri == 5'h15 && accepted_stage == '0 |->
      return_addr == $past(stage_pc[31:0]) + 32'h2)
      else $error("supervisor call return wrong");
endmodule
`default_nettype wire

/* tb/event_source_model.sv */
// event source model: keeps raised events pending until accepted
`timescale 1ns/1ns
`default_nettype none
module event_source_model (
   input wire logic clk, // cpu clock
   input wire logic sys_rst, // synchronous reset
   input wire logic [83:0] raise, // newly raised event bits
   input wire logic flush, // drop every pending event
   input wire logic take, // accept pulse from the unit
   input wire logic [1:0] accepted_stage, // stage accepted
   input wire logic [4:0] accepted_pri, // priority accepted
   output logic [83:0] stage_events // pending events
);
   logic [83:0] next_stage_events; // next pending set
   // raise adds bits, an accept clears only the accepted bit
   always_comb begin
      next_stage_events = stage_events | raise;
      if (take && accepted_pri != 5'h00) begin
         next_stage_events[accepted_stage*28 + accepted_pri - 1] = 1'b0;
      end
      if (sys_rst || flush) begin
         next_stage_events = '0;
      end
   end
   // register the pending set
   always_ff @(posedge clk) begin
      stage_events <= next_stage_events;
   end
endmodule
`default_nettype wire

/* tb/tb_event_priority_vectoring.sv */
// self-checking bench for the event priority and vectoring unit
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, ex, got) begin \
   check_count++; \
   if ((got) !== (ex)) begin \
      failures++; \
      $display("wrong value %s expected %h seen %h", nm, ex, got); \
   end end
module tb_event_priority_vectoring;
   import event_vec_pkg::*;
   // one case: one or two raised events, mask, expected winner
   typedef struct {
      logic [1:0] sa; logic [4:0] pa; logic [1:0] sb; logic [4:0] pb;
      logic [27:0] mask; logic tk; logic [4:0] pri; logic [1:0] st;
   } row_s;
   logic clk, sys_rst, flush, take; // clock, reset, handshakes
   logic [83:0] ev, stage_events; // raised and pending events
   logic [27:0] mask_in, mask_out; // masks before and after
   logic [31:0] handler_addr, return_addr; // unit answers
   logic [4:0] accepted_pri; // winner priority
   logic [1:0] accepted_stage; // winner stage
   logic [95:0] stage_pc = {32'h0000_3300, 32'h0000_2200, 32'h0000_1100};
   logic [31:0] fnc = 32'h0000_2000; // first non-completed pc
   logic [31:0] base = 32'h0002_000c; // overlaps offsets: or differs
   logic [13:0] autovec = 14'h3ffc; // full width autovector
   logic [31:0] dbg = 32'h9000_0000; // debug handler address
   int failures = 0, check_count = 0;
   row_s rows [13] = '{
      '{2'h0, 5'h05, 2'h0, 5'h00, 28'h0, 1'b1, 5'h05, 2'h0},
      '{2'h0, 5'h06, 2'h0, 5'h00, 28'h0, 1'b1, 5'h06, 2'h0},
      '{2'h1, 5'h02, 2'h0, 5'h00, 28'h0, 1'b1, 5'h02, 2'h1},
      '{2'h0, 5'h15, 2'h0, 5'h00, 28'h0, 1'b1, 5'h15, 2'h0},
      '{2'h2, 5'h10, 2'h0, 5'h14, 28'h0, 1'b1, 5'h14, 2'h0},
      '{2'h1, 5'h09, 2'h1, 5'h03, 28'h0, 1'b1, 5'h03, 2'h1},
      '{2'h0, 5'h08, 2'h0, 5'h00, 28'h0, 1'b1, 5'h08, 2'h0},
      '{2'h0, 5'h13, 2'h0, 5'h1c, 28'h0, 1'b0, 5'h00, 2'h0},
      '{2'h0, 5'h0c, 2'h0, 5'h00, 28'h800, 1'b0, 5'h00, 2'h0},
      '{2'h0, 5'h0c, 2'h0, 5'h07, 28'h840, 1'b1, 5'h07, 2'h0},
      '{2'h0, 5'h01, 2'h0, 5'h00, 28'h0, 1'b1, 5'h01, 2'h0},
      '{2'h1, 5'h0f, 2'h0, 5'h00, 28'h0, 1'b1, 5'h0f, 2'h1},
      '{2'h0, 5'h0c, 2'h2, 5'h03, 28'h0, 1'b1, 5'h0c, 2'h0}};
   event_source_model i_event_source_model (.clk(clk), .sys_rst(sys_rst),
      .raise(ev), .flush(flush), .take(take),
      .accepted_stage(accepted_stage),
      .accepted_pri(accepted_pri), .stage_events(stage_events));
   event_priority_vectoring i_event_priority_vectoring (.clk(clk),
      .sys_rst(sys_rst), .stage_events(stage_events), .stage_pc(stage_pc),
      .first_noncompleted_pc(fnc), .event_vector_base(base),
      .autovector(autovec), .debug_target(dbg), .mask_in(mask_in),
      .take(take), .handler_addr(handler_addr), .return_addr(return_addr),
      .accepted_pri(accepted_pri), .accepted_stage(accepted_stage),
      .mask_out(mask_out));
   // expected handler target for a priority
   function automatic logic [31:0] exp_handler(input logic [4:0] p);
      if (p == 5'h01) return RESET_ADDR;
      if (p == 5'h02) return dbg;
      if (p >= 5'h08 && p <= 5'h0b) return base | {18'h0, autovec};
      return base | EV_OFFSET[p - 1];
   endfunction
   // expected saved address for a priority and stage
   function automatic logic [31:0] exp_ret(input logic [4:0] p,
         input logic [1:0] s);
      if (p inside {5'h02, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0a,
            5'h0b, 5'h0f}) return fnc;
      if (p == 5'h15) return stage_pc[s*32 +: 32] + SCALL_RET_INC;
      return stage_pc[s*32 +: 32];
   endfunction
   // expected masks: winner and below set unless unmaskable
   function automatic logic [27:0] exp_mask(input logic [4:0] p,
         input logic [27:0] m);
      for (int k = 0; k < 28; k++) begin
         if (k >= p - 1 && !UNMASKABLE[k]) m[k] = 1'b1;
      end
      return m;
   endfunction
   // raise one case, await the accept, compare, then flush
   task automatic run_row(input row_s r);
      logic [83:0] v;
      v = '0;
      v[r.sa*28 + r.pa - 1] = 1'b1;
      if (r.pb != 5'h00) v[r.sb*28 + r.pb - 1] = 1'b1;
      @(posedge clk);
      mask_in <= r.mask;
      ev <= v;
      @(posedge clk);
      ev <= '0;
      for (int i = 0; i < 4 && take !== 1'b1; i++) begin
         @(posedge clk);
         #1;
      end
      `CHK("take", r.tk, take)
      if (r.tk) begin
         `CHK("priority", r.pri, accepted_pri)
         `CHK("stage", r.st, accepted_stage)
         `CHK("handler", exp_handler(r.pri), handler_addr)
         if (r.pri != 5'h01)
            `CHK("return", exp_ret(r.pri, r.st), return_addr)
         `CHK("masks", exp_mask(r.pri, r.mask), mask_out)
      end
      @(posedge clk);
      flush <= 1'b1;
      @(posedge clk);
      flush <= 1'b0;
      repeat (3) @(posedge clk);
   endtask
   // verdict and end of run
   task automatic end_sim();
      $display("checks %0d failures %0d", check_count, failures);
      if (failures == 0 && check_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   // 25 MHz clock
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // watchdog against a hang
   initial begin
      #40000;
      failures++;
      end_sim();
   end
   // main sequence: table, then reset in mid-run
   initial begin
      sys_rst = 1'b1;
      flush = 1'b0;
      ev = '0;
      mask_in = '0;
      repeat (2) @(posedge clk);
      sys_rst <= 1'b0;
      foreach (rows[i]) run_row(rows[i]);
      @(posedge clk);
      ev <= 84'h10;
      @(posedge clk);
      ev <= '0;
      sys_rst <= 1'b1;
      repeat (2) @(posedge clk);
      #1;
      `CHK("reset take", 1'b0, take)
      `CHK("reset handler", RESET_ADDR, handler_addr)
      `CHK("reset masks", 28'h0, mask_out)
      // release reset on an edge and show the unit recovers
      @(posedge clk);
      sys_rst <= 1'b0;
      run_row(rows[12]);
      end_sim();
   end
endmodule
`default_nettype wire
